/* File: design/mpdp_pkg.sv */
// package: constants and carriers for the parallel display host port
package mpdp_pkg;
  // bus width and pixel format
  localparam int          DATA_W          = 18;
  localparam int          PIX_R_W         = 5;
  localparam int          PIX_G_W         = 6;
  localparam int          PIX_B_W         = 5;
  localparam int          PIX_B_LSB       = 0;
  localparam int          PIX_G_LSB       = 5;
  localparam int          PIX_R_LSB       = 11;
  // bus style encoding
  localparam logic        STYLE_SEPARATE  = 1'b0;
  localparam logic        STYLE_ENABLE    = 1'b1;
  // timing: reference cycle and counts in reference cycles
  localparam int          CLK_PERIOD_NS   = 4;
  localparam int          REF_CYCLE_NS    = 9;
  localparam int          SEL_LOW_REF     = 1;
  localparam int          SEL_HIGH_REF    = 1;
  localparam int          FIRST_RD_REF    = 5;
  // least times round up to whole clock cycles
  localparam int          FIRST_RD_NS     = FIRST_RD_REF * REF_CYCLE_NS;
  localparam int          FIRST_RD_CYC    = (FIRST_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W           = 4;
  localparam logic [3:0]  FIRST_RD_CNT    = FIRST_RD_CYC[3:0];
  // pipeline reset values
  localparam logic [17:0] DATA_RESET      = 18'h00000;

  // one accepted write toward the controller core
  typedef struct packed {
    logic              is_data;  // high: data, low: command
    logic [DATA_W-1:0] word;     // bus word
  } mpdp_wr_s;

  // unpacked 565 pixel
  typedef struct packed {
    logic [PIX_R_W-1:0] red;
    logic [PIX_G_W-1:0] green;
    logic [PIX_B_W-1:0] blue;
  } mpdp_pix_s;
endpackage

/* File: design/mpdp_port.sv */
// file: device side of the parallel display host port
`timescale 1ns/1ns
module mpdp_port
  import mpdp_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       style_i,
  input  wire logic                       chip_sel_n_i,
  input  wire logic                       cmd_data_select_i,
  input  wire logic                       wr_strobe_i,
  input  wire logic                       rd_strobe_i,
  input  wire logic [mpdp_pkg::DATA_W-1:0] parallel_data_bus_i,
  output logic      [mpdp_pkg::DATA_W-1:0] parallel_data_bus_o,
  output logic      [mpdp_pkg::DATA_W-1:0] parallel_data_bus_oe_n_o,
  output logic                            wr_valid_o,
  output mpdp_pkg::mpdp_wr_s              wr_o,
  output mpdp_pkg::mpdp_pix_s             pix_o,
  output logic                            rd_req_o,
  output logic                            rd_is_data_o,
  input  wire logic [mpdp_pkg::DATA_W-1:0] rd_word_i
);
  import mpdp_pkg::*;

  // =====================================
  // pin synchronisation
  localparam int PIN_W = 4 + DATA_W;
  logic [PIN_W-1:0] pins_sync;             // synchronised pins
  logic             cs_n_s;                // chip select, synced
  logic             cds_s;                 // command/data select, synced
  logic             wr_s;                  // write strobe or enable, synced
  logic             rd_s;                  // read strobe or direction, synced
  logic [DATA_W-1:0] db_s;                 // bus word, synced

  mpdp_sync #(
    .WIDTH (PIN_W),
    .INIT  ({4'hF, DATA_RESET})
  ) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({chip_sel_n_i, cmd_data_select_i, wr_strobe_i, rd_strobe_i,
                 parallel_data_bus_i}),
    .sync_o    (pins_sync)
  );

  assign {cs_n_s, cds_s, wr_s, rd_s, db_s} = pins_sync;

  // =====================================
  // style capture, taken once after reset release
  logic       style_s;         // bus style pin, synced
  logic       style;           // held bus style
  logic [2:0] style_wait;      // marks edges since reset release
  logic       next_style;
  logic [2:0] next_style_wait;

  // the style strap is a pin too, so it is synchronised before use
  mpdp_sync #(
    .WIDTH (1),
    .INIT  (STYLE_SEPARATE)
  ) u_style_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (style_i),
    .sync_o    (style_s)
  );

  // style taken once the synchroniser shows the pin, then frozen
  always_comb
  begin
    next_style      = style;
    next_style_wait = {style_wait[1:0], 1'b1};
    if (style_wait == 3'h3)
      next_style = style_s;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      style       <= STYLE_SEPARATE;
      style_wait  <= 3'h0;
    end
    else
    begin
      style       <= next_style;
      style_wait  <= next_style_wait;
    end
  end

  // =====================================
  // access decode
  logic wr_prev;        // previous write strobe level
  logic rd_prev;        // previous read strobe level
  logic cs_prev;        // previous select level
  logic wr_take;        // write is taken this cycle
  logic rd_active;      // a read access is under way
  logic rd_start;       // a read access begins

  always_comb
  begin
    wr_take   = 1'b0;
    rd_active = 1'b0;
    rd_start  = 1'b0;
    if (style == STYLE_SEPARATE)
    begin
      // write taken on strobe rise while selected
      wr_take   = !cs_n_s && wr_s && !wr_prev;
      rd_active = !cs_n_s && !rd_s;
      rd_start  = rd_active && (rd_prev || cs_prev);
    end
    else
    begin
      // enable latches on its rising edge; direction from read line
      wr_take   = !cs_n_s && wr_s && !wr_prev && !rd_s;
      rd_active = !cs_n_s && rd_s && !wr_s;
      rd_start  = rd_active && (wr_prev || cs_prev || !rd_prev);
    end
  end

  // =====================================
  // read latency and bus drive state
  logic [CNT_W-1:0]  rd_cnt;        // cycles since read start
  logic              rd_first;      // first read of sequence still pending
  logic [CNT_W-1:0]  next_rd_cnt;
  logic              next_rd_first;
  logic [DATA_W-1:0] next_bus;
  logic [DATA_W-1:0] next_oe_n;
  logic              next_rd_req;
  logic              next_rd_is_data;

  // hold bus data back for the first read until latency passes
  always_comb
  begin
    next_rd_cnt     = rd_cnt;
    next_rd_first   = rd_first;
    next_bus        = parallel_data_bus_o;
    next_oe_n       = {DATA_W{1'b1}};
    next_rd_req     = 1'b0;
    next_rd_is_data = rd_is_data_o;
    if (cs_n_s)
    begin
      // deselect ends the read sequence
      next_rd_first = 1'b1;
      next_rd_cnt   = '0;
    end
    else if (rd_active)
    begin
      next_oe_n = {DATA_W{1'b0}};
      if (rd_start)
      begin
        next_rd_req     = 1'b1;
        next_rd_is_data = cds_s;
        next_rd_cnt     = '0;
      end
      else if (rd_first && rd_cnt < FIRST_RD_CNT)
        next_rd_cnt = rd_cnt + 4'h1;
      if (!rd_first || rd_cnt >= FIRST_RD_CNT)
      begin
        next_bus      = rd_word_i;
        next_rd_first = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_cnt                   <= '0;
      rd_first                 <= 1'b1;
      parallel_data_bus_o      <= DATA_RESET;
      parallel_data_bus_oe_n_o <= {DATA_W{1'b1}};
      rd_req_o                 <= 1'b0;
      rd_is_data_o             <= 1'b0;
    end
    else
    begin
      rd_cnt                   <= next_rd_cnt;
      rd_first                 <= next_rd_first;
      parallel_data_bus_o      <= next_bus;
      parallel_data_bus_oe_n_o <= next_oe_n;
      rd_req_o                 <= next_rd_req;
      rd_is_data_o             <= next_rd_is_data;
    end
  end

  // =====================================
  // write output stage
  mpdp_wr_s  next_wr;
  mpdp_pix_s next_pix;
  logic      next_wr_valid;

  // publish accepted word and its 565 unpacking
  always_comb
  begin
    next_wr       = wr_o;
    next_pix      = pix_o;
    next_wr_valid = wr_take;
    if (wr_take)
    begin
      next_wr.is_data = cds_s;
      next_wr.word    = db_s;
      next_pix.red    = db_s[PIX_R_LSB +: PIX_R_W];
      next_pix.green  = db_s[PIX_G_LSB +: PIX_G_W];
      next_pix.blue   = db_s[PIX_B_LSB +: PIX_B_W];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_prev    <= 1'b1;
      rd_prev    <= 1'b1;
      cs_prev    <= 1'b1;
      wr_valid_o <= 1'b0;
      wr_o       <= '0;
      pix_o      <= '0;
    end
    else
    begin
      wr_prev    <= wr_s;
      rd_prev    <= rd_s;
      cs_prev    <= cs_n_s;
      wr_valid_o <= next_wr_valid;
      wr_o       <= next_wr;
      pix_o      <= next_pix;
    end
  end
endmodule

/* File: design/mpdp_sync.sv */
// file: two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ns
module mpdp_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  // first stage, read only by second
  logic [WIDTH-1:0] stage1;

  // =====================================
  // two stage capture
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stage1 <= INIT;
      sync_o <= INIT;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

/* File: verif/mpdp_host.sv */
// partner: microcontroller on the parallel bus
`timescale 1ns/1ns
module mpdp_host
  import mpdp_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   style_i,
  output logic                        cs_n_o,
  output logic                        cd_o,
  output logic                        wr_o,
  output logic                        rd_o,
  output logic                        en_o,
  output logic [mpdp_pkg::DATA_W-1:0] d_o
);
  // ==========================
  // bus idle: deselected, released
  initial
  begin
    cs_n_o = 1'b1;
    cd_o   = 1'b0;
    wr_o   = 1'b1;
    rd_o   = 1'b1;
    en_o   = 1'b0;
    d_o    = '0;
  end
  task automatic idle();
    cs_n_o <= 1'b1;
    wr_o   <= 1'b1;
    rd_o   <= ~style_i;
    en_o   <= 1'b0;
  endtask
  // one access; strobe phase lasts hold clocks, later phases 3 clocks, above one reference cycle
  task automatic xfer(input logic rd, input logic sel, input logic cd,
                      input logic [17:0] d, input int hold);
    @(posedge clk_i);
    cs_n_o <= ~sel;
    cd_o   <= cd;
    d_o    <= d;
    en_o   <= ~rd;
    wr_o   <= rd & ~style_i;
    rd_o   <= rd ~^ style_i;
    repeat (hold) @(posedge clk_i);
    if (!rd)
    begin
      wr_o <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
    cs_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    idle();
  endtask
endmodule

/* File: verif/mpdp_port_asserts.sv */
// checker: pin timing relations of the host port
`timescale 1ns/1ns
module mpdp_chk
  import mpdp_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    reset_n_i,
  input wire logic                    chip_sel_n_i,
  input wire logic                    cmd_data_select_i,
  input wire logic [mpdp_pkg::DATA_W-1:0] parallel_data_bus_i,
  input wire logic [mpdp_pkg::DATA_W-1:0] parallel_data_bus_oe_n_o,
  input wire logic                    wr_valid_o,
  input wire mpdp_pkg::mpdp_wr_s      wr_o,
  input wire mpdp_pkg::mpdp_pix_s     pix_o,
  input wire logic                    rd_req_o,
  input wire logic                    rd_is_data_o
);
  // ==========================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_wr_pulse: assert property (wr_valid_o |=> !wr_valid_o)
    else $error("write pulse too long");
  chk_rd_pulse: assert property (rd_req_o |=> !rd_req_o)
    else $error("read pulse too long");
  chk_sel_gate: assert property (wr_valid_o |-> !$past(chip_sel_n_i, 3))
    else $error("write taken while deselected");
  chk_wr_word: assert property (wr_valid_o |->
    wr_o == {$past(cmd_data_select_i, 3), $past(parallel_data_bus_i, 3)})
    else $error("write word mismatch");
  chk_pix_map: assert property (pix_o == wr_o.word[15:0])
    else $error("pixel fields misplaced");
  chk_rd_drive: assert property (rd_req_o |-> parallel_data_bus_oe_n_o == '0)
    else $error("bus not driven on read");
  chk_wr_quiet: assert property (wr_valid_o |-> &parallel_data_bus_oe_n_o)
    else $error("bus driven on write");
  chk_idle_release: assert property (chip_sel_n_i [*4] |-> &parallel_data_bus_oe_n_o)
    else $error("bus driven while deselected");
  chk_rd_class: assert property (rd_req_o |-> rd_is_data_o == $past(cmd_data_select_i, 3))
    else $error("read class mismatch");
  // main scenarios seen
  cover property (wr_valid_o && wr_o.is_data);
  cover property (wr_valid_o && !wr_o.is_data);
  cover property (rd_req_o);
endmodule
bind mpdp_port mpdp_chk u_chk (
  .clk_i                    (clk_i),
  .reset_n_i                (reset_n_i),
  .chip_sel_n_i             (chip_sel_n_i),
  .cmd_data_select_i        (cmd_data_select_i),
  .parallel_data_bus_i      (parallel_data_bus_i),
  .parallel_data_bus_oe_n_o (parallel_data_bus_oe_n_o),
  .wr_valid_o               (wr_valid_o),
  .wr_o                     (wr_o),
  .pix_o                    (pix_o),
  .rd_req_o                 (rd_req_o),
  .rd_is_data_o             (rd_is_data_o)
);

/* File: verif/tb_top.sv */
// testbench: host port scenarios
`timescale 1ns/1ns
module tb_top;
  import mpdp_pkg::*;
  logic clk_i, reset_n_i, style_i, cs_n, cd, wr, rd, en;
  logic [17:0] hd, bus_i, bus_o, oe_n, rd_word, e_bus, d_bus;
  logic wr_valid, rd_req, rd_is_data, e_oe, lcd;
  mpdp_wr_s wr_s, lw;
  mpdp_pix_s pix, lp;
  int failures = 0, compares = 0, cyc = 0, nwr = 0, nrd = 0, rc = 100;
  // released host lines show the inverse of their last value
  assign bus_i = (bus_o & ~oe_n) | ((en ? hd : ~hd) & oe_n);
  mpdp_host host (.clk_i(clk_i), .style_i(style_i), .cs_n_o(cs_n), .cd_o(cd),
    .wr_o(wr), .rd_o(rd), .en_o(en), .d_o(hd));
  mpdp_port dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .style_i(style_i),
    .chip_sel_n_i(cs_n), .cmd_data_select_i(cd), .wr_strobe_i(wr), .rd_strobe_i(rd),
    .parallel_data_bus_i(bus_i), .parallel_data_bus_o(bus_o),
    .parallel_data_bus_oe_n_o(oe_n), .wr_valid_o(wr_valid), .wr_o(wr_s), .pix_o(pix),
    .rd_req_o(rd_req), .rd_is_data_o(rd_is_data), .rd_word_i(rd_word));
  // ==========================
  // clock, monitor, timeout
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (wr_valid === 1'b1)
    begin
      nwr <= nwr + 1;
      lw  <= wr_s;
      lp  <= pix;
    end
    rc <= (rd_req === 1'b1) ? 1 : rc + 1;
    if (rd_req === 1'b1)
    begin
      nrd   <= nrd + 1;
      e_oe  <= oe_n[0];
      lcd   <= rd_is_data;
    end
    // bus as driven 44 ns after the read pins moved: must not hold data yet
    if (rc == 8)
      e_bus <= bus_o;
    if (rc == 13)
      d_bus <= bus_o;
    // ceiling far above the whole run; reaching it counts as a mismatch
    if (cyc == 2000)
    begin
      failures++;
      summarize();
    end
  end
  // ==========================
  // compare and verdict
  task automatic check(input string n, input logic [18:0] e, input logic [18:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================
  // scenarios
  task automatic t_reset(input logic s);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    style_i   <= s;
    repeat (8) @(posedge clk_i);
    host.idle();
    #1;
    check("oe_n", 19'h3FFFF, {1'b0, oe_n});
    check("pulses", 19'h0, {17'h0, wr_valid, rd_req});
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic t_write(input logic sel, input logic c, input logic [17:0] d);
    int n;
    n = nwr;
    host.xfer(1'b0, sel, c, d, 3);
    #1;
    check("count", 19'(n + sel), 19'(nwr));
    if (sel)
    begin
      check("word", {c, d}, lw);
      check("pixel", {3'h0, d[15:0]}, {3'h0, lp});
    end
  endtask
  task automatic t_read(input logic sel, input logic c, input logic [17:0] v);
    int n;
    n = nrd;
    @(posedge clk_i);
    rd_word <= v;
    host.xfer(1'b1, sel, c, 18'h00000, 20);
    #1;
    check("rd count", 19'(n + sel), 19'(nrd));
    if (sel)
    begin
      check("early", 19'h0, {18'h0, e_bus === v});
      check("rd oe", 19'h0, {18'h0, e_oe});
      check("rd class", {18'h0, c}, {18'h0, lcd});
      check("rd data", {1'b0, v}, {1'b0, d_bus});
    end
    check("released", 19'h3FFFF, {1'b0, oe_n});
  endtask
  initial
  begin
    reset_n_i = 1'b0;
    style_i   = STYLE_SEPARATE;
    rd_word   = 18'h00000;
    t_reset(STYLE_SEPARATE);
    t_write(1'b1, 1'b0, 18'h2A5C3);
    t_write(1'b1, 1'b1, 18'h1F81F);
    t_write(1'b0, 1'b1, 18'h00FF0);
    t_read(1'b1, 1'b1, 18'h3C3C3);
    t_read(1'b0, 1'b1, 18'h2B2B2);
    t_reset(STYLE_ENABLE);
    t_write(1'b1, 1'b1, 18'h0F0F5);
    t_read(1'b1, 1'b0, 18'h15A5A);
    summarize();
  end
endmodule
